//--- uoc_pkg.sv
package uoc_pkg;
    // register indexes, byte address is four times each
    localparam logic [13:0] IDX_OTGCON = 14'h0606;
    localparam logic [13:0] IDX_PWRC = 14'h0608;
    localparam logic [13:0] IDX_IR = 14'h060a;
    localparam logic [13:0] IDX_IE = 14'h060c;
    localparam logic [13:0] IDX_EIR = 14'h060e;
    localparam logic [13:0] IDX_EIE = 14'h0610;
    localparam logic [13:0] IDX_CON = 14'h0614;
    localparam logic [13:0] IDX_ADDR = 14'h0616;
    localparam logic [13:0] IDX_TOK = 14'h061e;
    localparam logic [13:0] IDX_EP0 = 14'h062a;
    localparam logic [7:0] REG_RST = 8'h00;
    // descriptor status word fields
    localparam int BD_OWN = 15;
    localparam int BD_TSEL = 14;
    localparam int BD_TSYNC = 11;
    localparam int BD_STALL = 10;
    // top flag positions
    localparam int IR_ERR = 1;
    localparam int IR_SOF = 2;
    localparam int IR_TRN = 3;
    localparam int IR_ATT = 6;
    localparam int IR_STL = 7;
    // control bit positions
    localparam int CON_EN = 0;
    localparam int CON_PPR = 1;
    localparam int CON_HOST = 3;
    localparam int CON_URST = 4;
    localparam int CON_SE0 = 6;
    localparam int CON_J = 7;
    localparam int OTG_DPU = 7;
    localparam int OTG_DMU = 6;
    localparam int OTG_DPD = 5;
    localparam int OTG_DMD = 4;
    localparam int OTG_EN = 2;
    localparam int PWR_ON = 0;
    localparam int EP_LS = 7;
    localparam int EP_STL = 1;
    localparam int EP_HS = 0;
    localparam int ADDR_LS = 7;
    // packet identifiers
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_ACK = 4'h2;
    localparam logic [3:0] PID_NAK = 4'ha;
    localparam logic [3:0] PID_STALL = 4'he;
    localparam logic [3:0] PID_DATA0 = 4'h3;
    localparam logic [3:0] PID_DATA1 = 4'hb;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int FRAME_LOAD_DEF = 12000;
    // token or host result from the link logic
    typedef struct packed {
        logic valid;
        logic [3:0] pid;
        logic [3:0] ep;
        logic tog;
        logic [9:0] cnt;
        logic status_ph;
    } uoc_tok_t;
    // descriptor status write-back
    typedef struct packed {
        logic valid;
        logic [3:0] ep;
        logic tx;
        logic odd;
        logic [15:0] data;
    } uoc_bdw_t;
    // handshake or data pid to send
    typedef struct packed {
        logic valid;
        logic [3:0] pid;
    } uoc_hs_t;
    // host token launch toward the link
    typedef struct packed {
        logic valid;
        logic [3:0] pid;
        logic [3:0] ep;
        logic [6:0] addr;
        logic ls;
    } uoc_htok_t;
endpackage : uoc_pkg

//--- uoc_top.sv
`timescale 1ns/1ps
module uoc_top
    import uoc_pkg::*;
#(
    parameter int FRAME_LOAD = FRAME_LOAD_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic dp_in,
    input wire logic dm_in,
    input wire uoc_tok_t link_tok,
    input wire logic [15:0] bd_stat,
    input wire logic [7:0] err_evt,
    output uoc_bdw_t bd_wr,
    output uoc_hs_t hs_out,
    output uoc_htok_t host_tok,
    output logic dp_pullup,
    output logic dm_pullup,
    output logic dp_pulldown,
    output logic dm_pulldown,
    output logic phy_power,
    output logic bus_reset_out,
    output logic sof_pulse,
    output logic irq
);
    // one-hot register match, shared by write and read paths
    function automatic logic uoc_hit(input logic [13:0] idx);
        logic h;
        h = 1'b0;
        if (idx == IDX_OTGCON) begin
            h = 1'b1;
        end else if (idx == IDX_PWRC) begin
            h = 1'b1;
        end else if (idx == IDX_IR || idx == IDX_IE) begin
            h = 1'b1;
        end else if (idx == IDX_EIR || idx == IDX_EIE) begin
            h = 1'b1;
        end else if (idx == IDX_CON || idx == IDX_ADDR) begin
            h = 1'b1;
        end else if (idx == IDX_TOK || idx == IDX_EP0) begin
            h = 1'b1;
        end
        return h;
    endfunction : uoc_hit

    localparam logic [13:0] FRM_LOAD = 14'(FRAME_LOAD);

    // software-visible registers
    logic [7:0] otg_r; // pullups, pulldowns, dual role
    logic [7:0] pwr_r; // module power
    logic [7:0] ir_r; // top event flags
    logic [7:0] ie_r; // top event enables
    logic [7:0] eir_r; // error event flags
    logic [7:0] eie_r; // error event enables
    logic [7:0] con_r; // host, bus reset, pingpong reset
    logic usb_en_r; // module enable, device view of bit 0
    logic sof_en_r; // frame marker enable, host view of bit 0
    logic [7:0] addr_r; // device address and low speed
    logic [7:0] ep0_r; // endpoint 0 control
    // bus slave state
    logic awready_r;
    logic wready_r;
    logic aw_full_r; // address held
    logic w_full_r; // data held
    logic [13:0] aw_idx_r;
    logic [7:0] wd_r;
    logic wstb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    // line sampling
    logic [1:0] ln_s1_r;
    logic [1:0] ln_s2_r;
    logic [1:0] ln_s3_r;
    logic [1:0] ln_r; // agreed D+/D- level
    logic [1:0] ln_prev_r;
    // frames, pingpong, outputs
    logic host_prev_r;
    logic [13:0] frm_r;
    logic [31:0] pp_r; // odd pointer per endpoint and direction
    logic [3:0] htok_pid_r; // last launched host token
    uoc_bdw_t bd_wr_r;
    uoc_hs_t hs_r;
    uoc_htok_t htok_r;
    logic sof_r;
    logic irq_r;
    logic urst_out_r;
    logic [7:0] pad_r; // pullup/pulldown/power pins

    // write decode
    wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_en = wr_go & wstb_r & uoc_hit(aw_idx_r);
    wire wr_otg = wr_en & (aw_idx_r == IDX_OTGCON);
    wire wr_pwr = wr_en & (aw_idx_r == IDX_PWRC);
    wire wr_ir = wr_en & (aw_idx_r == IDX_IR);
    wire wr_ie = wr_en & (aw_idx_r == IDX_IE);
    wire wr_eir = wr_en & (aw_idx_r == IDX_EIR);
    wire wr_eie = wr_en & (aw_idx_r == IDX_EIE);
    wire wr_con = wr_en & (aw_idx_r == IDX_CON);
    wire wr_addr = wr_en & (aw_idx_r == IDX_ADDR);
    wire wr_tok = wr_en & (aw_idx_r == IDX_TOK);
    wire wr_ep0 = wr_en & (aw_idx_r == IDX_EP0);
    wire host = con_r[CON_HOST];

    // line state
    wire se0 = (ln_r == 2'b00);
    wire attach_ev = host & (ln_prev_r == 2'b00) & ~se0;
    wire host_rise = host & ~host_prev_r;
    wire sof_ev = host & sof_en_r & (frm_r == 14'h0000);

    // token decision
    wire own = bd_stat[BD_OWN];
    wire tsel = bd_stat[BD_TSEL];
    wire tsync = bd_stat[BD_TSYNC];
    wire bstl = bd_stat[BD_STALL];
    wire dev_on = usb_en_r & ~host;
    wire t_tx = host ? (htok_pid_r != PID_IN) : (link_tok.pid == PID_IN);
    wire stat_auto = dev_on & link_tok.valid & link_tok.status_ph
        & (link_tok.ep == 4'h0);
    wire t_go = link_tok.valid & usb_en_r & ~stat_auto;
    wire t_nak = t_go & ~own;
    wire t_stall = t_go & own & bstl;
    // toggle checked only on incoming data and only with sync on
    wire t_togbad = t_go & own & ~bstl & tsync & ~t_tx
        & (link_tok.tog != tsel);
    wire t_done = t_go & own & ~bstl & ~t_togbad;
    wire [9:0] bc_new = t_tx ? bd_stat[9:0] : link_tok.cnt;
    wire stall_ev = t_stall | (host & t_done & (link_tok.pid == PID_STALL));
    wire [4:0] pp_idx = {link_tok.ep, t_tx};
    wire hs_en = dev_on & ((link_tok.ep != 4'h0) | ep0_r[EP_HS]);

    // flag next values: a set in the same cycle as a clear wins
    wire err_sum = |(eir_r & eie_r);
    wire [7:0] ir_set = {stall_ev, attach_ev, 2'b00, t_done, sof_ev, err_sum, 1'b0};
    wire [7:0] ir_nxt = (ir_r & ~(wr_ir ? wd_r : 8'h00)) | ir_set;
    wire [7:0] eir_nxt = (eir_r & ~(wr_eir ? wd_r : 8'h00)) | err_evt;

    // read mux
    logic [7:0] rd_val;
    wire [13:0] ar_idx = araddr[15:2];
    always_comb begin
        rd_val = 8'h00;
        if (ar_idx == IDX_OTGCON) begin
            rd_val = otg_r;
        end else if (ar_idx == IDX_PWRC) begin
            rd_val = pwr_r;
        end else if (ar_idx == IDX_IR) begin
            rd_val = ir_r;
        end else if (ar_idx == IDX_IE) begin
            rd_val = ie_r;
        end else if (ar_idx == IDX_EIR) begin
            rd_val = eir_r;
        end else if (ar_idx == IDX_EIE) begin
            rd_val = eie_r;
        end else if (ar_idx == IDX_CON) begin
            // live line bits; bit 0 follows the current role
            rd_val = {ln_r[1], se0, 1'b0, con_r[4:1],
                host ? sof_en_r : usb_en_r};
        end else if (ar_idx == IDX_ADDR) begin
            rd_val = addr_r;
        end else if (ar_idx == IDX_TOK) begin
            rd_val = {htok_pid_r, htok_r.ep};
        end else if (ar_idx == IDX_EP0) begin
            rd_val = ep0_r;
        end
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_idx_r <= 14'h0000;
            wd_r <= 8'h00;
            wstb_r <= 1'b0;
        end else begin
            if (awvalid & awready_r) begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                aw_idx_r <= awaddr[15:2];
            end
            if (wvalid & wready_r) begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                wd_r <= wdata[7:0];
                wstb_r <= wstrb[0];
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
            end
            // reopen both channels once the response is taken
            if (bvalid_r & bready) begin
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // write response; unmapped index answers slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OK;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= uoc_hit(aw_idx_r) ? RESP_OK : RESP_ERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read channel, data registered on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OK;
            rdata_r <= 32'h0000_0000;
        end else if (arvalid & arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= uoc_hit(ar_idx) ? RESP_OK : RESP_ERR;
            rdata_r <= {24'h000000, rd_val};
        end else if (rvalid_r & rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // plain control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            otg_r <= REG_RST;
            pwr_r <= REG_RST;
            ie_r <= REG_RST;
            eie_r <= REG_RST;
            addr_r <= REG_RST;
        end else begin
            if (wr_otg) otg_r <= wd_r & 8'hf5;
            if (wr_pwr) pwr_r <= wd_r & 8'h01;
            if (wr_ie) ie_r <= wd_r;
            if (wr_eie) eie_r <= wd_r;
            // low speed address bit exists only in host role
            if (wr_addr) addr_r <= {wd_r[ADDR_LS] & host, wd_r[6:0]};
        end
    end

    // module control; bus reset and frame bits need host role
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            con_r <= REG_RST;
            usb_en_r <= 1'b0;
            sof_en_r <= 1'b0;
        end else begin
            if (wr_con) begin
                con_r[CON_HOST] <= wd_r[CON_HOST];
                con_r[CON_PPR] <= wd_r[CON_PPR];
                con_r[CON_URST] <= wd_r[CON_URST] & host;
            end
            if (wr_con & ~host) usb_en_r <= wd_r[CON_EN];
            if (host_rise) begin
                sof_en_r <= 1'b1;
            end else if (wr_con & host) begin
                sof_en_r <= wd_r[CON_EN];
            end
        end
    end

    // endpoint 0 control; stall bit also set by hardware
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ep0_r <= REG_RST;
        end else begin
            if (wr_ep0) ep0_r <= {wd_r[EP_LS] & host, wd_r[6:0]};
            if (stall_ev & (link_tok.ep == 4'h0)) ep0_r[EP_STL] <= 1'b1;
        end
    end

    // event flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_r <= REG_RST;
            eir_r <= REG_RST;
            irq_r <= 1'b0;
        end else begin
            ir_r <= ir_nxt;
            eir_r <= eir_nxt;
            irq_r <= |(ir_r & ie_r);
        end
    end

    // D+/D- through three stages; a change counts once two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ln_s1_r <= 2'b00;
            ln_s2_r <= 2'b00;
            ln_s3_r <= 2'b00;
            ln_r <= 2'b00;
            ln_prev_r <= 2'b00;
        end else begin
            ln_s1_r <= {dp_in, dm_in};
            ln_s2_r <= ln_s1_r;
            ln_s3_r <= ln_s2_r;
            if (ln_s2_r == ln_s3_r) ln_r <= ln_s3_r;
            ln_prev_r <= ln_r;
        end
    end

    // frame marker counter, loaded on host entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_prev_r <= 1'b0;
            frm_r <= FRM_LOAD;
            sof_r <= 1'b0;
        end else begin
            host_prev_r <= host;
            sof_r <= sof_ev;
            if (host_rise | sof_ev) begin
                frm_r <= FRM_LOAD;
            end else if (host & sof_en_r) begin
                frm_r <= frm_r - 14'h0001;
            end
        end
    end

    // pingpong pointers toggle per completed buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pp_r <= 32'h0000_0000;
        end else if (con_r[CON_PPR]) begin
            pp_r <= 32'h0000_0000;
        end else if (t_done) begin
            pp_r[pp_idx] <= ~pp_r[pp_idx];
        end
    end

    // descriptor write-back: owner cleared with pid and count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bd_wr_r <= '0;
        end else begin
            bd_wr_r.valid <= t_done;
            bd_wr_r.ep <= link_tok.ep;
            bd_wr_r.tx <= t_tx;
            bd_wr_r.odd <= pp_r[pp_idx];
            // token pid in device role, returned pid in host role
            bd_wr_r.data <= {1'b0, tsel, link_tok.pid, bc_new};
        end
    end

    // handshake or data pid toward the link, device role only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_r <= '0;
        end else begin
            hs_r.valid <= hs_en & link_tok.valid;
            if (t_nak) begin
                hs_r.pid <= PID_NAK;
            end else if (t_stall) begin
                hs_r.pid <= PID_STALL;
            end else if (t_done & t_tx) begin
                hs_r.pid <= tsel ? PID_DATA1 : PID_DATA0;
            end else begin
                hs_r.pid <= PID_ACK;
            end
        end
    end

    // host token launch from a token register write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            htok_r <= '0;
            htok_pid_r <= 4'h0;
        end else begin
            htok_r.valid <= wr_tok & host;
            if (wr_tok & host) begin
                htok_pid_r <= wd_r[7:4];
                htok_r.pid <= wd_r[7:4];
                htok_r.ep <= wd_r[3:0];
                htok_r.addr <= addr_r[6:0];
                htok_r.ls <= ep0_r[EP_LS];
            end
        end
    end

    // pad controls and bus reset signalling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_r <= REG_RST;
            urst_out_r <= 1'b0;
        end else begin
            pad_r <= {otg_r[7:4], 3'b000, pwr_r[PWR_ON] & otg_r[OTG_EN]};
            urst_out_r <= host & con_r[CON_URST];
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign bd_wr = bd_wr_r;
    assign hs_out = hs_r;
    assign host_tok = htok_r;
    assign dp_pullup = pad_r[OTG_DPU];
    assign dm_pullup = pad_r[OTG_DMU];
    assign dp_pulldown = pad_r[OTG_DPD];
    assign dm_pulldown = pad_r[OTG_DMD];
    assign phy_power = pad_r[0];
    assign bus_reset_out = urst_out_r;
    assign sof_pulse = sof_r;
    assign irq = irq_r;
endmodule : uoc_top

//--- uoc_asserts.sv
`timescale 1ns/1ps
module uoc_chk
    import uoc_pkg::*;
#(
    parameter int FRAME_LOAD = FRAME_LOAD_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire uoc_tok_t link_tok,
    input wire logic [15:0] bd_stat,
    input wire uoc_bdw_t bd_wr,
    input wire uoc_hs_t hs_out,
    input wire logic sof_pulse
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int gap_r; // cycles since the last frame marker
    logic seen_r; // a frame marker has been seen
    // spacing tracker for frame markers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_r <= 1'b0;
            gap_r <= 0;
        end else if (sof_pulse) begin
            seen_r <= 1'b1;
            gap_r <= 0;
        end else if (gap_r < 100000) begin
            gap_r <= gap_r + 1;
        end
    end
    own_ignore_a: assert property (link_tok.valid && !bd_stat[BD_OWN] |=> !bd_wr.valid)
        else $error("write to cpu owned descriptor");
    stall_keep_a: assert property (link_tok.valid && bd_stat[BD_OWN] && bd_stat[BD_STALL] |=> !bd_wr.valid)
        else $error("stalled descriptor was written");
    stall_cause_a: assert property (hs_out.valid && hs_out.pid == PID_STALL |-> $past(bd_stat[BD_STALL]))
        else $error("stall without stall bit");
    own_clear_a: assert property (bd_wr.valid |-> !bd_wr.data[BD_OWN])
        else $error("owner not returned");
    wr_pid_a: assert property (bd_wr.valid |-> bd_wr.data[13:10] == $past(link_tok.pid))
        else $error("wrong pid written");
    wr_tsel_a: assert property (bd_wr.valid |-> bd_wr.data[BD_TSEL] == $past(bd_stat[BD_TSEL]))
        else $error("toggle bit changed");
    wr_cause_a: assert property (bd_wr.valid |-> $past(link_tok.valid && bd_stat[BD_OWN]))
        else $error("write without owned token");
    wr_count_a: assert property (bd_wr.valid |->
        bd_wr.data[9:0] == (bd_wr.tx ? $past(bd_stat[9:0]) : $past(link_tok.cnt)))
        else $error("wrong byte count");
    hs_cause_a: assert property (hs_out.valid |-> $past(link_tok.valid))
        else $error("handshake without token");
    sof_gap_a: assert property (sof_pulse && seen_r |-> gap_r >= FRAME_LOAD - 1)
        else $error("frame markers too close");
endmodule : uoc_chk
bind uoc_top uoc_chk #(.FRAME_LOAD(FRAME_LOAD)) u_chk (.aclk(aclk), .aresetn(aresetn), .link_tok(link_tok),
    .bd_stat(bd_stat), .bd_wr(bd_wr), .hs_out(hs_out), .sof_pulse(sof_pulse));

//--- uoc_link_model.sv
`timescale 1ns/1ps
module uoc_link_model
    import uoc_pkg::*;
(
    input wire logic aclk,
    input wire uoc_bdw_t bd_wr,
    input wire uoc_hs_t hs_out,
    input wire uoc_htok_t host_tok,
    output uoc_tok_t link_tok,
    output logic [15:0] bd_stat,
    output logic dp_in,
    output logic dm_in
);
    logic [15:0] desc; // descriptor word in shared memory
    logic [3:0] hs; // last handshake sent
    logic [3:0] hpid; // last host token pid
    // bus starts in single-ended zero
    initial begin
        link_tok = '0;
        bd_stat = 16'h0;
        dp_in = 1'b0;
        dm_in = 1'b0;
        hpid = 4'h0;
    end
    // memory is loaded by each token, otherwise changes only by module write-back while owned
    always @(posedge aclk) begin
        if (bd_wr.valid) desc <= bd_wr.data;
        if (hs_out.valid) hs <= hs_out.pid;
        if (host_tok.valid) hpid <= host_tok.pid;
    end
    // one token with its descriptor for a single cycle
    task automatic tok(input logic [15:0] s, input logic [3:0] p, input logic [3:0] e, input logic t,
                       input logic [9:0] c, input logic sp);
        @(posedge aclk);
        desc = s;
        hs = 4'h0;
        link_tok <= '{1'b1, p, e, t, c, sp};
        bd_stat <= s;
        @(posedge aclk);
        link_tok <= '{1'b0, ~p, ~e, ~t, ~c, ~sp};
        bd_stat <= ~s; // released lines show the inverse
    endtask : tok
    // device pulls d plus high: SE0 to J
    task automatic attach();
        @(posedge aclk);
        dp_in <= 1'b1;
    endtask : attach
endmodule : uoc_link_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench import uoc_pkg::*;;
    localparam int FL = 20; // short frame for simulation
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr, araddr, bd_stat;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, last_b;
    logic dp_in, dm_in, dp_pullup, dm_pullup, dp_pulldown, dm_pulldown, phy_power, bus_reset_out, sof_pulse, irq;
    logic [7:0] err_evt;
    uoc_tok_t link_tok;
    uoc_bdw_t bd_wr;
    uoc_hs_t hs_out;
    uoc_htok_t host_tok;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    // token rows: status, pid, ep, toggle, count, status stage, expected word, expected pid
    typedef struct {logic [15:0] s; logic [3:0] p; logic [3:0] e; logic t; logic [9:0] c; logic sp;
        logic [15:0] x; logic [3:0] h;} uoc_row_t;
    uoc_row_t rows [7] = '{
        '{16'hc005, PID_IN, 4'h1, 1'b0, 10'h0, 1'b0, 16'h6405, PID_DATA1},
        '{16'h8040, 4'h1, 4'h1, 1'b0, 10'h3, 1'b0, 16'h0403, PID_ACK},
        '{16'h0040, 4'h1, 4'h1, 1'b0, 10'h3, 1'b0, 16'h0040, PID_NAK},
        '{16'hc840, 4'h1, 4'h1, 1'b0, 10'h2, 1'b0, 16'hc840, PID_ACK},
        '{16'hc040, 4'h1, 4'h1, 1'b0, 10'h2, 1'b0, 16'h4402, PID_ACK},
        '{16'h8040, 4'h1, 4'h0, 1'b0, 10'h0, 1'b1, 16'h8040, PID_ACK},
        '{16'h8440, 4'h1, 4'h0, 1'b0, 10'h2, 1'b0, 16'h8440, PID_STALL}};
    uoc_top #(.FRAME_LOAD(FL)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .dp_in(dp_in), .dm_in(dm_in), .link_tok(link_tok),
        .bd_stat(bd_stat), .err_evt(err_evt), .bd_wr(bd_wr), .hs_out(hs_out), .host_tok(host_tok),
        .dp_pullup(dp_pullup), .dm_pullup(dm_pullup), .dp_pulldown(dp_pulldown), .dm_pulldown(dm_pulldown),
        .phy_power(phy_power), .bus_reset_out(bus_reset_out), .sof_pulse(sof_pulse), .irq(irq));
    uoc_link_model lnk (.aclk(aclk), .bd_wr(bd_wr), .hs_out(hs_out), .host_tok(host_tok), .link_tok(link_tok),
        .bd_stat(bd_stat), .dp_in(dp_in), .dm_in(dm_in));
    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("MISMATCH %0t timeout", $time);
        conclude();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        cmp_count++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc
    // register write, address and data offered together
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {a, 2'b00};
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        last_b = bresp;
        bready <= 1'b0;
    endtask : wr
    // register read, compared under a mask
    task automatic rd(input logic [13:0] a, input logic [7:0] x, input logic [7:0] mk);
        @(posedge aclk);
        araddr <= {a, 2'b00};
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata & {24'h0, mk}, {24'h0, x}, "read");
        chk(32'(rresp), 32'(RESP_OK), "rresp");
    endtask : rd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, err_evt} = '0;
        wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_IR, 8'h00, 8'hff);
        wr(14'h0700, 8'h55);
        chk(32'(last_b), 32'(RESP_ERR), "unmapped");
        wr(IDX_CON, 8'h02);
        wr(IDX_CON, 8'h00);
        wr(IDX_IE, 8'h00);
        wr(IDX_EIE, 8'h00);
        wr(IDX_IR, 8'hff);
        wr(IDX_EIR, 8'hff);
        wr(IDX_CON, 8'h01);
        wr(IDX_OTGCON, 8'h04);
        wr(IDX_EP0, 8'h09);
        wr(IDX_PWRC, 8'h01);
        wr(IDX_OTGCON, 8'h84);
        cyc(2);
        chk(32'({phy_power, dp_pullup, dm_pullup}), 32'h6, "power");
        wr(IDX_ADDR, 8'hff);
        rd(IDX_ADDR, 8'h7f, 8'hff);
        $display("setup test done");
        foreach (rows[i]) begin
            lnk.tok(rows[i].s, rows[i].p, rows[i].e, rows[i].t, rows[i].c, rows[i].sp);
            cyc(3);
            chk(32'(lnk.desc), 32'(rows[i].x), "descriptor");
            chk(32'(lnk.hs), 32'(rows[i].h), "handshake");
        end
        rd(IDX_IR, 8'h88, 8'hff);
        rd(IDX_EP0, 8'h0b, 8'hff);
        wr(IDX_IR, 8'h00);
        rd(IDX_IR, 8'h88, 8'hff);
        wr(IDX_IR, 8'h08);
        rd(IDX_IR, 8'h80, 8'hff);
        wr(IDX_IR, 8'h80);
        $display("token test done");
        wr(IDX_EIE, 8'h01);
        wr(IDX_IE, 8'h02);
        err_evt <= 8'h01;
        @(posedge aclk);
        err_evt <= 8'h00;
        cyc(3);
        rd(IDX_EIR, 8'h01, 8'hff);
        rd(IDX_IR, 8'h02, 8'h02);
        chk(32'(irq), 32'h1, "irq");
        wr(IDX_EIR, 8'h01);
        wr(IDX_IR, 8'h02);
        cyc(2);
        chk(32'(irq), 32'h0, "irq");
        $display("error test done");
        wr(IDX_OTGCON, 8'h30);
        wr(IDX_CON, 8'h09);
        n = 0;
        while (sof_pulse !== 1'b1 && n < 3 * FL) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(sof_pulse), 32'h1, "frame");
        chk(32'({dp_pulldown, dm_pulldown, dp_pullup}), 32'h6, "pulls");
        wr(IDX_IE, 8'h40);
        lnk.attach();
        cyc(10);
        rd(IDX_IR, 8'h40, 8'h40);
        chk(32'(irq), 32'h1, "attach irq");
        rd(IDX_CON, 8'h80, 8'h80);
        wr(IDX_ADDR, 8'hff);
        rd(IDX_ADDR, 8'hff, 8'hff);
        wr(IDX_CON, 8'h19);
        cyc(2);
        chk(32'(bus_reset_out), 32'h1, "bus reset");
        wr(IDX_CON, 8'h08);
        cyc(2);
        n = 0;
        repeat (3 * FL) begin
            @(posedge aclk);
            n += 32'(sof_pulse);
        end
        chk(32'(n), 32'h0, "frames stopped");
        wr(IDX_TOK, 8'h90);
        cyc(3);
        chk(32'(lnk.hpid), 32'(PID_IN), "host token");
        $display("host test done");
        aresetn <= 1'b0;
        cyc(2);
        chk(32'({awready, wready, arready, bvalid, irq, bus_reset_out}), 32'h38, "reset");
        aresetn <= 1'b1;
        rd(IDX_CON, 8'h00, 8'h1f);
        $display("reset test done");
        conclude();
    end
endmodule : testbench
